// file: core/t16_params.svh
// Purpose: Offsets, field positions, reset values and counts of the 16-bit timer clock/capture block.
// Assumes: Included by bare name; definitions only.
// Notes:   Register indices are word indices; the byte address is four times the index.
`ifndef T16_PARAMS_SVH
`define T16_PARAMS_SVH

// ************************************************************
// Register indices (byte address = index * 4).
// ************************************************************
`define T16_IDX_CTRL     10'h081
`define T16_IDX_COUNT    10'h084
`define T16_IDX_CAPT     10'h086
`define T16_IDX_STAT     10'h088
`define T16_IDX_MASK     10'h089

// ************************************************************
// Reset values and field positions.
// ************************************************************
`define T16_CTRL_RESET   8'h00
`define T16_CTRL_WMASK   8'hdf
`define T16_CTRL_RSVD    5
`define T16_STAT_CAPT    0
`define T16_STAT_OVF     1
`define T16_STAT_RESET   2'h0
`define T16_MASK_RESET   2'h0
`define T16_CNT_MAX      16'hffff

// ************************************************************
// Timing counts.
// ************************************************************
`define T16_FILT_SAMPLES 4
`define T16_PRE_WIDTH    10

`endif

// file: core/t16_pkg.sv
// Purpose: Types shared by the 16-bit timer clock/capture block.
// Assumes: Constants live in t16_params.svh.
// Notes:   State of each module is one packed struct.

package t16_pkg;

	// Counter clock source selection, in field order.
	typedef enum logic [2:0] {
		T16_CS_STOP,
		T16_CS_SYS,
		T16_CS_DIV8,
		T16_CS_DIV64,
		T16_CS_DIV256,
		T16_CS_DIV1024,
		T16_CS_EXT_FALL,
		T16_CS_EXT_RISE
	} t16_clk_sel_t;

	// Control register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic         capture_filter_enable;
		logic         capture_edge_select;
		logic         rsvd;
		logic         wave_mode_bit3;
		logic         wave_mode_bit2;
		t16_clk_sel_t clk_select_field;
	} t16_ctrl_t;

	// Prescaler tap enables: bit 0 is /8, then /64, /256, /1024.
	typedef logic [3:0] t16_taps_t;

	// Capture and external clock pins travel together.
	typedef struct packed {
		logic capture_input_pin;
		logic ext_count_clock_pin;
	} t16_pins_t;

	// Whole state of the control block.
	typedef struct packed {
		t16_ctrl_t   ctrl;
		logic [15:0] cnt;
		logic [15:0] capt;
		logic [1:0]  stat;
		logic [1:0]  mask;
		logic        cap_s1;
		logic        cap_s2;
		logic [2:0]  hist;
		logic        flt;
		logic        prev_lvl;
		logic        ext_s1;
		logic        ext_s2;
		logic        ext_prev;
		logic [31:0] prdata;
	} t16_state_t;

endpackage

// file: core/t16_prescaler.sv
// Purpose: Free-running system clock prescaler giving one-cycle tap enables.
// Assumes: Single clock pclk; asynchronous active-low reset.
// Notes:   Each tap pulses once every 2^k cycles, k from TAP_BITS.
`timescale 1ns/1ps
`default_nettype none
`include "t16_params.svh"

module t16_prescaler
	import t16_pkg::*;
#(
	parameter int W = `T16_PRE_WIDTH
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Tap enables.
	output var t16_taps_t taps
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed {
		logic [W-1:0] cnt;
	} t16_pre_state_t;

	localparam int TAP_BITS [4] = '{3, 6, 8, 10};

	t16_pre_state_t s_r;   // Registered state.
	t16_pre_state_t s_nxt; // Next state.

	// The divider simply counts every cycle.
	always_comb begin
		s_nxt = s_r;
		s_nxt.cnt = s_r.cnt + 1'b1;
	end

	// Register the state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// A tap fires when its low bits are all ones, so every tap is one cycle wide.
	for (genvar i = 0; i < 4; i++) begin : g_tap
		assign taps[i] = &s_r.cnt[TAP_BITS[i]-1:0];
	end

endmodule
`default_nettype wire

// file: core/t16_ctrl.sv
// Purpose: Control register B logic of a 16-bit timer: capture filter, edge, mode bits, clock select.
// Assumes: APB slave on pclk; pins synchronous to pclk but resynchronised anyway.
// Notes:   Counter, capture value, status and mask registers sit beside the control register.
//
// What this block does
// [R01] Filter enable bit turns on capture filter.
// [R02] Filtered input needs four equal samples.
// [R03] Filter adds four cycles of capture delay.
// [R04] Filter off: pin goes straight to edge.
// [R05] Edge bit one rising, zero falling.
// [R06] Capture copies counter into capture register.
// [R07] Capture sets flag; enabled flag raises interrupt.
// [R08] Bits four and three are mode bits.
// [R09] Low three bits select counter clock.
// [R10] Select zero stops the counter.
// [R11] Select one to five: sys, /8../1024.
// [R12] Select six counts external pin falling edges.
// [R13] Select seven counts external pin rising edges.
// [R14] Control register resets to zero.
// [R15] Pins synchronised; one action per edge.
// [R16] Reserved bit five reads zero.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "t16_params.svh"

module t16_ctrl
	import t16_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// External pins.
	input  wire t16_pins_t   pins,
	// Timer side outputs.
	output logic [15:0]      counter_value,
	output logic             wave_mode_bit3,
	output logic             wave_mode_bit2,
	output logic             irq
);

	// ************************************************************
	// Declarations.
	// ************************************************************
	t16_state_t  s_r;      // Registered state.
	t16_state_t  s_nxt;    // Next state.
	t16_taps_t   taps;     // Prescaler enables.
	logic [9:0]  idx;      // Word index of the access.
	logic        setup;    // APB setup cycle.
	logic        access;   // APB access cycle, always completes.
	logic        mapped;   // Index hits a register.
	logic        lvl;      // Capture level seen by edge detection.
	logic        trig;     // Capture trigger this cycle.
	logic        cnt_en;   // Counter advances this cycle.
	logic        ext_rise; // Synchronised external clock rose.
	logic        ext_fall; // Synchronised external clock fell.
	logic [1:0]  set_ev;   // Status events this cycle.
	logic [1:0]  clr_ev;   // Status bits cleared by a read.

	// ************************************************************
	// Prescaler.
	// ************************************************************
	t16_prescaler #(
		.W (`T16_PRE_WIDTH)
	) u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.taps    (taps)
	);

	// ************************************************************
	// Bus decode.
	// ************************************************************
	// Every access completes in its first access cycle.
	assign idx     = paddr[11:2];
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign pready  = access;
	assign mapped  = (idx == `T16_IDX_CTRL) || (idx == `T16_IDX_COUNT) ||
	                 (idx == `T16_IDX_CAPT) || (idx == `T16_IDX_STAT) ||
	                 (idx == `T16_IDX_MASK);
	assign pslverr = access && !mapped;

	// Read data, counter and mode bits come straight from state flip-flops.
	assign prdata         = s_r.prdata;
	assign counter_value  = s_r.cnt;
	assign wave_mode_bit3 = s_r.ctrl.wave_mode_bit3; // R08
	assign wave_mode_bit2 = s_r.ctrl.wave_mode_bit2; // R08
	// Level interrupt from any unmasked sticky status bit.
	assign irq            = |(s_r.stat & s_r.mask); // R07

	// ************************************************************
	// Next-state logic.
	// ************************************************************
	always_comb begin
		s_nxt = s_r;

		// Two-stage synchronisers; only stage two is looked at.
		s_nxt.cap_s1   = pins.capture_input_pin; // R15
		s_nxt.cap_s2   = s_r.cap_s1;
		s_nxt.ext_s1   = pins.ext_count_clock_pin; // R15
		s_nxt.ext_s2   = s_r.ext_s1;
		s_nxt.ext_prev = s_r.ext_s2;

		// The filter keeps a short history; the level moves only when the
		// newest sample and three before it agree.
		s_nxt.hist = {s_r.hist[1:0], s_r.cap_s2};
		if ((&{s_r.hist, s_r.cap_s2}) == 1'b1) begin // R02
			s_nxt.flt = 1'b1;
		end else if ((|{s_r.hist, s_r.cap_s2}) == 1'b0) begin // R02
			s_nxt.flt = 1'b0;
		end

		// Filtered level costs four cycles; raw level costs none.
		if (s_r.ctrl.capture_filter_enable) begin // R01 R03
			lvl = s_r.flt;
		end else begin
			lvl = s_r.cap_s2; // R04
		end
		s_nxt.prev_lvl = lvl;

		// Edge choice: one detected edge gives one trigger.
		if (s_r.ctrl.capture_edge_select) begin
			trig = lvl && !s_r.prev_lvl; // R05
		end else begin
			trig = !lvl && s_r.prev_lvl; // R05
		end

		// External clock edges on the synchronised pin.
		ext_rise = s_r.ext_s2 && !s_r.ext_prev; // R15
		ext_fall = !s_r.ext_s2 && s_r.ext_prev; // R15

		// Counter clock selection by the low field alone.
		case (s_r.ctrl.clk_select_field) // R09
			T16_CS_STOP:     cnt_en = 1'b0;       // R10
			T16_CS_SYS:      cnt_en = 1'b1;       // R11
			T16_CS_DIV8:     cnt_en = taps[0];    // R11
			T16_CS_DIV64:    cnt_en = taps[1];    // R11
			T16_CS_DIV256:   cnt_en = taps[2];    // R11
			T16_CS_DIV1024:  cnt_en = taps[3];    // R11
			T16_CS_EXT_FALL: cnt_en = ext_fall;   // R12
			T16_CS_EXT_RISE: cnt_en = ext_rise;   // R13
			default:         cnt_en = 1'b0;
		endcase

		// Counter with wrap; the wrap is also a status event.
		set_ev = 2'h0;
		if (cnt_en) begin
			s_nxt.cnt = s_r.cnt + 16'h0001;
			set_ev[`T16_STAT_OVF] = (s_r.cnt == `T16_CNT_MAX);
		end

		// Capture takes the value before this cycle's increment.
		if (trig) begin
			s_nxt.capt = s_r.cnt; // R06
			set_ev[`T16_STAT_CAPT] = 1'b1; // R07
		end

		// A status read clears only what it returned, so an event that
		// lands after the setup cycle is kept; a set beats a clear.
		clr_ev = 2'h0;
		if (access && !pwrite && (idx == `T16_IDX_STAT)) begin
			clr_ev = s_r.prdata[1:0];
		end
		s_nxt.stat = (s_r.stat & ~clr_ev) | set_ev; // R07

		// Read data is fetched in the setup cycle.
		if (setup) begin
			case (idx)
				`T16_IDX_CTRL:  s_nxt.prdata = {24'h000000, s_r.ctrl}; // R16
				`T16_IDX_COUNT: s_nxt.prdata = {16'h0000, s_r.cnt};
				`T16_IDX_CAPT:  s_nxt.prdata = {16'h0000, s_r.capt};
				`T16_IDX_STAT:  s_nxt.prdata = {30'h00000000, s_r.stat};
				`T16_IDX_MASK:  s_nxt.prdata = {30'h00000000, s_r.mask};
				default:        s_nxt.prdata = 32'h00000000;
			endcase
		end

		// Writes take effect at the completing edge.
		if (access && pwrite) begin
			case (idx)
				`T16_IDX_CTRL: begin
					// Reserved bit is dropped on write.
					s_nxt.ctrl = t16_ctrl_t'(pwdata[7:0] & `T16_CTRL_WMASK); // R16
				end
				`T16_IDX_MASK: begin
					s_nxt.mask = pwdata[1:0];
				end
				default: begin
					s_nxt.mask = s_nxt.mask;
				end
			endcase
		end
	end

	// ************************************************************
	// State register.
	// ************************************************************
	// Everything resets to zero; the control word gives a stopped timer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r      <= '0;
			s_r.ctrl <= t16_ctrl_t'(`T16_CTRL_RESET); // R14
			s_r.stat <= `T16_STAT_RESET;
			s_r.mask <= `T16_MASK_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Four synchronised high samples with the filter on.
	sequence s_four_high;
		(s_r.ctrl.capture_filter_enable && s_r.cap_s2)[*4];
	endsequence

	// Raw rising edge while the filter stays off, rising edges chosen.
	sequence s_raw_rise;
		!s_r.ctrl.capture_filter_enable && $past(!s_r.ctrl.capture_filter_enable)
		&& s_r.ctrl.capture_edge_select && $rose(s_r.cap_s2);
	endsequence

	a_reserved_zero: assert property (s_r.ctrl.rsvd == 1'b0) // R16
		else $error("Reserved control bit is set.");

	a_stop_hold: assert property (
		(s_r.ctrl.clk_select_field == T16_CS_STOP) |=> $stable(s_r.cnt)) // R10
		else $error("Counter moved while stopped.");

	a_sys_count: assert property (
		(s_r.ctrl.clk_select_field == T16_CS_SYS) |=> (s_r.cnt == $past(s_r.cnt) + 16'h0001)) // R11
		else $error("Counter did not advance on system clock.");

	a_div8_gate: assert property (
		(s_r.ctrl.clk_select_field == T16_CS_DIV8) && !taps[0] |=> $stable(s_r.cnt)) // R11
		else $error("Counter advanced without its tap.");

	a_ext_fall: assert property (
		(s_r.ctrl.clk_select_field == T16_CS_EXT_FALL) && !s_r.ext_s2 && s_r.ext_prev
		|=> (s_r.cnt == $past(s_r.cnt) + 16'h0001)) // R12
		else $error("Falling external edge not counted.");

	a_ext_rise_only: assert property (
		(s_r.ctrl.clk_select_field == T16_CS_EXT_RISE) && !(s_r.ext_s2 && !s_r.ext_prev)
		|=> $stable(s_r.cnt)) // R13
		else $error("Counter moved without a rising external edge.");

	a_capture_copy: assert property (trig |=> (s_r.capt == $past(s_r.cnt))) // R06
		else $error("Capture value is not the counter value.");

	a_capture_flag: assert property (trig |=> s_r.stat[`T16_STAT_CAPT]) // R07
		else $error("Capture flag not set.");

	a_capture_irq: assert property (trig && s_r.mask[`T16_STAT_CAPT] |=> irq) // R07
		else $error("Enabled capture did not raise the interrupt.");

	a_filter_accept: assert property (s_four_high |=> s_r.flt) // R02
		else $error("Four equal samples did not move the filter.");

	a_filter_reject: assert property (
		!s_r.flt && !(s_r.cap_s2 && (s_r.hist == 3'h7)) |=> !s_r.flt) // R02
		else $error("Filter moved on fewer than four samples.");

	a_raw_trigger: assert property (s_raw_rise |-> trig) // R04
		else $error("Unfiltered rising edge missed.");

	a_filter_delay: assert property (
		s_r.ctrl.capture_filter_enable && s_r.ctrl.capture_edge_select
		&& !s_r.flt && !s_r.prev_lvl && $rose(s_r.cap_s2) ##1 s_r.cap_s2[*3]
		|=> trig) // R03
		else $error("Filtered capture not four cycles after the raw edge.");

	a_falling_edge: assert property (
		!s_r.ctrl.capture_filter_enable && $past(!s_r.ctrl.capture_filter_enable)
		&& !s_r.ctrl.capture_edge_select && $rose(s_r.cap_s2) |-> !trig) // R05
		else $error("Rising edge triggered with falling edge chosen.");

	// A control write must land both mode bits from data bits four and three.
	a_mode_bits: assert property (
		access && pwrite && (idx == `T16_IDX_CTRL)
		|=> ({wave_mode_bit3, wave_mode_bit2} == $past(pwdata[4:3]))) // R08
		else $error("Mode bits do not follow the written control word.");

endmodule
`default_nettype wire

// file: sim/t16_pin_model.sv
// Purpose: Drives the capture and external clock pins of the timer block.
// Assumes: Pins change only just after a rising pclk edge.
// Notes:   Each level holds until the next call.
`timescale 1ns/1ps
`default_nettype none

module t16_pin_model
	import t16_pkg::*;
(
	// Clock.
	input  wire logic     pclk,
	// Pins towards the timer.
	output var t16_pins_t pins
);
	// Both pins idle low.
	initial pins = '0;

	// Sets the capture pin level just after the next edge.
	task automatic drive_cap(input logic lvl);
		@(posedge pclk);
		pins.capture_input_pin <= lvl;
	endtask

	// Sets the external clock pin level just after the next edge.
	task automatic drive_ext(input logic lvl);
		@(posedge pclk);
		pins.ext_count_clock_pin <= lvl;
	endtask
endmodule
`default_nettype wire

// file: sim/timer16_capture_clock_control_test.sv
// Purpose: Self-checking bench of the timer clock select and capture logic.
// Assumes: Zero wait-state APB slave; capture flag three edges after the pin with the filter off, seven with it on.
// Notes:   Counter deltas are measured between two read setup edges.
`timescale 1ns/1ps
`default_nettype none
`include "t16_params.svh"

module timer16_capture_clock_control_test
	import t16_pkg::*;
;
	// ************************************************************
	// Signals.
	// ************************************************************
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] counter_value;
	logic        wave_mode_bit3;
	logic        wave_mode_bit2;
	logic        irq;
	t16_pins_t   pins;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [31:0] rd;
	logic        err;
	logic [15:0] cv;
	int          divs [5] = '{1, 8, 64, 256, 1024};

	localparam logic [11:0] A_CTRL = {`T16_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_CNT  = {`T16_IDX_COUNT, 2'b00};
	localparam logic [11:0] A_CAPT = {`T16_IDX_CAPT, 2'b00};
	localparam logic [11:0] A_STAT = {`T16_IDX_STAT, 2'b00};
	localparam logic [11:0] A_MASK = {`T16_IDX_MASK, 2'b00};

	// 20 MHz clock.
	always #25 pclk = ~pclk;

	t16_ctrl u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins), .counter_value(counter_value), .wave_mode_bit3(wave_mode_bit3),
		.wave_mode_bit2(wave_mode_bit2), .irq(irq)
	);
	t16_pin_model u_pins (.pclk(pclk), .pins(pins));

	// ************************************************************
	// Tasks.
	// ************************************************************
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only pready or the bench timeout ends this wait.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Selects a clock, optionally moves the external pin, checks the count delta.
	task automatic cnt_test(input logic [7:0] ctrl, input int gap, input logic [15:0] exp,
			input logic use_ext, input logic lvl);
		logic [15:0] c0;
		apb(1'b1, A_CTRL, {24'h0, ctrl});
		apb(1'b0, A_CNT, 32'h0);
		c0 = rd[15:0];
		if (use_ext) u_pins.drive_ext(lvl);
		repeat (gap) @(posedge pclk);
		apb(1'b0, A_CNT, 32'h0);
		chk({16'h0, rd[15:0] - c0}, {16'h0, exp});
	endtask

	// Moves the capture pin and checks delay to irq, status, captured value.
	task automatic cap_test(input logic [7:0] ctrl, input logic lvl, input logic pulse,
			input int exp_n, input logic [31:0] exp_st);
		int n;
		apb(1'b1, A_CTRL, {24'h0, ctrl});
		repeat (8) @(posedge pclk);
		u_pins.drive_cap(lvl);
		if (pulse) begin
			repeat (2) @(posedge pclk);
			u_pins.drive_cap(!lvl);
		end
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (irq !== 1'b1 && n < 16);
		chk(32'(n), 32'(exp_n));
		apb(1'b0, A_STAT, 32'h0);
		chk(rd, exp_st);
		if (exp_st[0]) begin
			apb(1'b0, A_CAPT, 32'h0);
			chk(rd, {16'h0, cv});
		end
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
	endtask

	// Cuts a hang short; the wrap test alone needs nearly 65535 cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, A_CTRL, 32'hff);
		apb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'hdf);
		@(negedge pclk);
		chk({30'h0, wave_mode_bit3, wave_mode_bit2}, 32'h3);
		apb(1'b1, A_CTRL, 32'h10);
		@(negedge pclk);
		chk({30'h0, wave_mode_bit3, wave_mode_bit2}, 32'h2);
		apb(1'b0, 12'h300, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		cnt_test(8'h00, 20, 16'h0, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			cnt_test(8'(i + 1), 4 * divs[i] - 3, 16'h4, 1'b0, 1'b0);
		end
		cnt_test(8'h06, 6, 16'h0, 1'b1, 1'b1);
		cnt_test(8'h06, 6, 16'h1, 1'b1, 1'b0);
		cnt_test(8'h07, 6, 16'h1, 1'b1, 1'b1);
		cnt_test(8'h07, 6, 16'h0, 1'b1, 1'b0);
		apb(1'b1, A_CTRL, 32'h0);
		apb(1'b0, A_CNT, 32'h0);
		cv = rd[15:0];
		apb(1'b1, A_MASK, 32'h1);
		cap_test(8'h40, 1'b1, 1'b0, 4, 32'h1);
		cap_test(8'h40, 1'b0, 1'b0, 16, 32'h0);
		cap_test(8'h00, 1'b1, 1'b0, 16, 32'h0);
		cap_test(8'h00, 1'b0, 1'b0, 4, 32'h1);
		cap_test(8'hc0, 1'b1, 1'b0, 8, 32'h1);
		cap_test(8'hc0, 1'b0, 1'b1, 16, 32'h0);
		cap_test(8'h80, 1'b0, 1'b0, 8, 32'h1);
		apb(1'b1, A_MASK, 32'h0);
		cap_test(8'h40, 1'b1, 1'b0, 16, 32'h1);
		// Run on the system clock past the wrap; the wrap flag must raise irq.
		apb(1'b1, A_MASK, 32'h2);
		apb(1'b1, A_CTRL, 32'h01);
		apb(1'b0, A_CNT, 32'h0);
		repeat (32'(16'hffff - rd[15:0])) @(posedge pclk);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, A_STAT, 32'h0);
		chk(rd, 32'h2);
		complete_run();
	end
endmodule
`default_nettype wire
